/* File: common/alf_pkg.sv */
package alf_pkg;
    // frame geometry
    localparam int LANES = 10;
    localparam int CORES = 4;
    localparam int SETS = 5;
    localparam int SET_BYTES = 2 * CORES;
    localparam int SYM_W = 10;
    localparam logic [1:0] WORD_LAST = 2'h3;
    // register offsets
    localparam logic [4:0] ADDR_CORE_CFG = 5'h01;
    localparam logic [4:0] ADDR_PATTERN = 5'h0D;
    localparam logic [4:0] ADDR_SYNC = 5'h10;
    localparam logic [4:0] ADDR_SER_LANE = 5'h11;
    localparam logic [4:0] ADDR_TAB_A = 5'h12;
    localparam logic [4:0] ADDR_TAB_B = 5'h13;
    localparam logic [4:0] ADDR_SER_PAT = 5'h14;
    // field positions
    localparam int BIT_BUMP = 1;
    localparam int BIT_TEST_PAT = 3;
    localparam int BIT_NO_TRAIN = 14;
    localparam int SYNC_PHASE_LSB = 5;
    localparam int SYNC_DLY_LSB = 7;
    localparam int SYNC_DLY_W = 9;
    localparam int SER_MODE_LSB = 10;
    localparam logic [15:0] SYNC_RO_MASK = 16'h0060;
    // reset value of every register
    localparam logic [15:0] RST_REG = 16'h0000;
    // symbols and codes
    localparam logic [7:0] K27_7_BYTE = 8'hFB;
    localparam logic [7:0] K28_5_BYTE = 8'hBC;
    localparam logic [7:0] D5_6_BYTE = 8'hC5;
    localparam logic [9:0] K27_7_NEG = 10'h368;
    localparam logic [9:0] K27_7_POS = 10'h097;
    localparam logic [9:0] K28_5_NEG = 10'h0FA;
    localparam logic [9:0] K28_5_POS = 10'h305;
    localparam logic [7:0] CODE_LO = 8'h00;
    localparam logic [7:0] CODE_HI = 8'hFF;
    localparam logic [3:0] PAT_STEP = 4'hA;
    // serializer pattern modes
    localparam logic [2:0] SER_OFF = 3'h0;
    localparam logic [2:0] SER_LFSR_ALIGNED = 3'h1;
    localparam logic [2:0] SER_LFSR_STEP1 = 3'h2;
    localparam logic [2:0] SER_LFSR_STEP5 = 3'h3;
    localparam logic [2:0] SER_TABLE0 = 3'h4;
    localparam logic [2:0] SER_TABLE1 = 3'h5;
    localparam int LFSR_WIDE_STEP = 5;
    localparam int LFSR_PERIOD = 64;
    localparam logic [14:0] LFSR_SEED = 15'h7FFF;
    localparam int SYNC_TAPS_DEF = 32;

    typedef struct packed {
        logic [CORES-1:0][7:0] cur;
        logic [CORES-1:0][7:0] dly;
    } alf_set_t;
    typedef alf_set_t [SETS-1:0] alf_frame_t;
    typedef struct packed {
        logic k;
        logic [7:0] data;
    } alf_byte_t;
    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } alf_reg_req_t;
    typedef logic [LANES-1:0][SYM_W-1:0] alf_lanes_t;
endpackage

/* File: rtl/alf_encoder.sv */
`timescale 1ns/10ps
module alf_encoder (
    input wire logic clk,
    input wire logic reset_n,
    input alf_pkg::alf_byte_t din,
    output logic [alf_pkg::SYM_W-1:0] sym
);
    import alf_pkg::*;

    typedef struct packed {
        logic rd;
        logic [SYM_W-1:0] sym;
    } alf_enc_t;

    // 5b/6b and 3b/4b codes for negative running disparity, abcdei/fghj with a first
    localparam logic [31:0][5:0] T6 = {
        6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
        6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
        6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
        6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
    localparam logic [7:0][3:0] T4 = {
        4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
    localparam logic [3:0] ALT7 = 4'h7;

    alf_enc_t st;
    alf_enc_t next_st;

    // disparity-aware encode; rd low means negative running disparity
    always_comb begin
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] b6;
        logic [3:0] b4;
        logic mid;
        x = din.data[4:0];
        y = din.data[7:5];
        b6 = T6[x];
        b4 = T4[y];
        mid = st.rd;
        next_st = st;
        if (din.k) begin
            // only the start and comma control symbols are ever requested
            if (din.data == K27_7_BYTE) begin
                next_st.sym = st.rd ? K27_7_POS : K27_7_NEG;
            end else begin
                next_st.sym = st.rd ? K28_5_POS : K28_5_NEG;
            end
            next_st.rd = st.rd ^ ($countones(next_st.sym) != 5);
        end else begin
            if (st.rd && ($countones(b6) != 3 || x == 5'h07)) begin
                b6 = ~b6;
            end
            mid = st.rd ^ ($countones(b6) != 3);
            // alternate x.7 avoids a run of five equal bits
            if (y == 3'h7 && ((!mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                    (mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)))) begin
                b4 = ALT7;
            end
            if (mid && ($countones(b4) != 2 || y == 3'h3)) begin
                b4 = ~b4;
            end
            next_st.sym = {b6, b4};
            next_st.rd = mid ^ ($countones(b4) != 2);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sym = st.sym;
endmodule

/* File: rtl/alf_lfsr_gen.sv */
`timescale 1ns/10ps
module alf_lfsr_gen (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] mode,
    output alf_pkg::alf_lanes_t lanes
);
    import alf_pkg::*;

    localparam int HDEPTH = (LANES - 1) * LFSR_WIDE_STEP + 1;
    localparam int POS_W = $clog2(LFSR_PERIOD);

    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [14:0] lfsr;
        logic [HDEPTH-1:0][SYM_W-1:0] hist;
        alf_lanes_t lanes;
    } alf_gen_t;

    alf_gen_t st;
    alf_gen_t next_st;

    // one generator; lane staggering reads older entries of a symbol history
    always_comb begin
        logic [SYM_W-1:0] s;
        logic [14:0] r;
        int step;
        s = '0;
        r = st.lfsr;
        step = 0;
        next_st = st;
        next_st.pos = st.pos + 1'b1;
        if (st.pos == '0) begin
            s = K28_5_NEG;
        end else if (st.pos == POS_W'(1)) begin
            s = K28_5_POS;
            r = LFSR_SEED; // restart so every period repeats
        end else begin
            for (int b = 0; b < SYM_W; b++) begin
                r = {r[13:0], r[14] ^ r[13]};
                s[b] = r[0];
            end
        end
        next_st.lfsr = r;
        next_st.hist = {st.hist[HDEPTH-2:0], s};
        if (mode == SER_LFSR_STEP1) begin
            step = 1;
        end else if (mode == SER_LFSR_STEP5) begin
            step = LFSR_WIDE_STEP;
        end
        for (int l = 0; l < LANES; l++) begin
            next_st.lanes[l] = st.hist[l * step];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lanes = st.lanes;
endmodule

/* File: rtl/alf_lane_framer.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - frames are four words over ten lanes
// - order delayed A-D then current A-D
// - core mode never changes lane mapping
// - map, then encode, then serialize lanes
// - request high asserts, low releases
// - training replaces data on all lanes
// - training is eight fixed symbols in order
// - released request finishes current training sequence
// - request capture loads clock phase bits
// - each bump rise drops one clock
// - request passes programmable delay before use
// - suppress bit keeps data during request
// - test pattern gives low/high code sequence
// - test pattern data is mapped and encoded
// - serializer patterns bypass the encoder
// - pseudo-random period is sixty-four symbols
// - pseudo-random lanes aligned or staggered
// - table zero cycles slots or outputs zero
// - table one alternates slot pair per lane
module alf_lane_framer #(
    parameter int SYNC_TAPS = alf_pkg::SYNC_TAPS_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sync_request,
    input alf_pkg::alf_frame_t frame_in,
    input alf_pkg::alf_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic frame_take,
    output alf_pkg::alf_lanes_t lanes_out
);
    import alf_pkg::*;

    typedef enum logic {TX_DATA, TX_TRAIN} alf_tx_t;

    typedef struct packed {
        logic [1:0] sync_meta;
        logic [SYNC_TAPS-1:0] sync_line;
        logic req_q;
        logic [1:0] div4;
        logic bump_q;
        alf_tx_t tx;
        logic [2:0] tseq;
        alf_frame_t frame;
        logic [3:0] pat_idx;
        alf_byte_t [LANES-1:0] lane_byte;
        logic [1:0] slot;
        alf_lanes_t lanes;
        logic frame_take;
        logic [15:0] core_cfg;
        logic [15:0] pattern;
        logic [15:0] sync_reg;
        logic [15:0] ser_lane;
        logic [15:0] tab_a;
        logic [15:0] tab_b;
        logic [15:0] ser_pat;
        logic [15:0] rdata;
    } alf_main_t;

    alf_main_t st;
    alf_main_t next_st;
    logic req;
    logic swallow;
    logic [2:0] ser_mode;
    logic [LANES-1:0][SYM_W-1:0] enc_sym;
    alf_lanes_t lfsr_lanes;

    // byte of the continuous sample stream that lands on lane l in word w
    function automatic alf_byte_t map_byte(alf_frame_t f, logic [1:0] w, int l);
        int k;
        int s;
        int p;
        alf_byte_t b;
        k = int'(w) * LANES + l;
        s = k / SET_BYTES;
        p = k % SET_BYTES;
        b.k = 1'b0;
        b.data = (p < CORES) ? f[s].dly[p] : f[s].cur[p - CORES];
        return b;
    endfunction

    // training symbol for sequence position t
    function automatic alf_byte_t train_byte(logic [2:0] t);
        alf_byte_t b;
        b.k = !t[0];
        if (t == 3'h0) begin
            b.data = K27_7_BYTE;
        end else if (!t[0]) begin
            b.data = K28_5_BYTE;
        end else begin
            b.data = D5_6_BYTE;
        end
        return b;
    endfunction

    // low or high code from one bit of the pattern register
    function automatic logic [7:0] pat_code(logic [15:0] pat, logic [3:0] idx, int off);
        logic [3:0] i;
        i = idx + 4'(off);
        return pat[i] ? CODE_HI : CODE_LO;
    endfunction

    // all next-state logic of the formatter
    always_comb begin
        int tap;
        logic [39:0] tab_all;
        logic [3:0][SYM_W-1:0] tab;
        tap = 0;
        tab_all = {st.ser_pat[SYM_W-1:0], st.tab_b[13:0], st.tab_a};
        tab = tab_all;
        next_st = st;

        // delayed request; taps beyond the line length clamp to the last one
        tap = int'(st.sync_reg[SYNC_DLY_LSB +: SYNC_DLY_W]);
        if (tap > SYNC_TAPS - 1) begin
            tap = SYNC_TAPS - 1;
        end
        req = st.sync_line[tap];
        next_st.sync_meta = {st.sync_meta[0], sync_request};
        next_st.sync_line = {st.sync_line[SYNC_TAPS-2:0], st.sync_meta[1]};
        next_st.req_q = req;

        // register writes; phase bits stay read-only
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_CORE_CFG: next_st.core_cfg = reg_req.wdata;
                ADDR_PATTERN: next_st.pattern = reg_req.wdata;
                ADDR_SYNC: next_st.sync_reg = (reg_req.wdata & ~SYNC_RO_MASK) |
                    (st.sync_reg & SYNC_RO_MASK);
                ADDR_SER_LANE: next_st.ser_lane = reg_req.wdata;
                ADDR_TAB_A: next_st.tab_a = reg_req.wdata;
                ADDR_TAB_B: next_st.tab_b = reg_req.wdata;
                ADDR_SER_PAT: next_st.ser_pat = reg_req.wdata;
                default: ;
            endcase
        end
        case (reg_req.addr)
            ADDR_CORE_CFG: next_st.rdata = st.core_cfg;
            ADDR_PATTERN: next_st.rdata = st.pattern;
            ADDR_SYNC: next_st.rdata = st.sync_reg;
            ADDR_SER_LANE: next_st.rdata = st.ser_lane;
            ADDR_TAB_A: next_st.rdata = st.tab_a;
            ADDR_TAB_B: next_st.rdata = st.tab_b;
            ADDR_SER_PAT: next_st.rdata = st.ser_pat;
            default: next_st.rdata = '0;
        endcase

        // phase capture on the rising edge of the delayed request
        if (req && !st.req_q) begin
            next_st.sync_reg[SYNC_PHASE_LSB +: 2] = st.div4;
        end

        // a bump rise holds the divider for one clock, shifting it one later
        swallow = st.core_cfg[BIT_BUMP] && !st.bump_q;
        next_st.bump_q = st.core_cfg[BIT_BUMP];
        next_st.div4 = swallow ? st.div4 : st.div4 + 2'h1;
        next_st.frame_take = (next_st.div4 == WORD_LAST);

        // training entry waits for a frame boundary so data resumes aligned
        case (st.tx)
            TX_DATA: begin
                if (req && !st.tab_b[BIT_NO_TRAIN] && st.div4 == WORD_LAST) begin
                    next_st.tx = TX_TRAIN;
                    next_st.tseq = 3'h0;
                end
            end
            TX_TRAIN: begin
                next_st.tseq = st.tseq + 3'h1;
                if (st.tseq == 3'h7 && (!req || st.tab_b[BIT_NO_TRAIN])) begin
                    next_st.tx = TX_DATA;
                end
            end
            default: next_st.tx = TX_DATA;
        endcase

        // next frame is taken on the last word; the core mode bits play no part
        if (st.div4 == WORD_LAST) begin
            if (st.core_cfg[BIT_TEST_PAT]) begin
                for (int s = 0; s < SETS; s++) begin
                    for (int c = 0; c < CORES; c++) begin
                        next_st.frame[s].dly[c] = pat_code(st.pattern, st.pat_idx, 2 * s);
                        next_st.frame[s].cur[c] = pat_code(st.pattern, st.pat_idx, 2 * s + 1);
                    end
                end
                next_st.pat_idx = st.pat_idx + PAT_STEP;
            end else begin
                next_st.frame = frame_in;
            end
        end

        // byte stage feeding the encoders, same path for test data
        for (int l = 0; l < LANES; l++) begin
            if (st.tx == TX_TRAIN) begin
                next_st.lane_byte[l] = train_byte(st.tseq);
            end else begin
                next_st.lane_byte[l] = map_byte(st.frame, st.div4, l);
            end
        end

        // serializer stage: patterns here never see the encoder
        ser_mode = st.ser_pat[SER_MODE_LSB +: 3];
        next_st.slot = st.slot + 2'h1;
        for (int l = 0; l < LANES; l++) begin
            case (ser_mode)
                SER_LFSR_ALIGNED, SER_LFSR_STEP1, SER_LFSR_STEP5: begin
                    next_st.lanes[l] = lfsr_lanes[l];
                end
                SER_TABLE0: next_st.lanes[l] = st.ser_lane[l] ? tab[st.slot] : '0;
                SER_TABLE1: next_st.lanes[l] = tab[{st.ser_lane[l], st.slot[0]}];
                default: next_st.lanes[l] = enc_sym[l];
            endcase
        end
    end

    // state register; reset restarts every counter at word zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
            st.core_cfg <= RST_REG;
            st.pattern <= RST_REG;
            st.sync_reg <= RST_REG;
            st.ser_lane <= RST_REG;
            st.tab_a <= RST_REG;
            st.tab_b <= RST_REG;
            st.ser_pat <= RST_REG;
        end else begin
            st <= next_st;
        end
    end

    // one encoder per lane keeps its own running disparity
    for (genvar l = 0; l < LANES; l++) begin : g_enc
        alf_encoder u_enc (
            .clk(clk),
            .reset_n(reset_n),
            .din(st.lane_byte[l]),
            .sym(enc_sym[l])
        );
    end

    alf_lfsr_gen u_lfsr (
        .clk(clk),
        .reset_n(reset_n),
        .mode(ser_mode),
        .lanes(lfsr_lanes)
    );

    assign reg_rdata = st.rdata;
    assign frame_take = st.frame_take;
    assign lanes_out = st.lanes;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_train_start:
    assert property ((st.tx == TX_TRAIN && st.tseq == 3'h0) |=>
        (st.lane_byte[0] == {1'b1, K27_7_BYTE} && st.lane_byte[LANES-1] == {1'b1, K27_7_BYTE}))
        else $error("training does not open with the start symbol");
    a_train_fill:
    assert property ((st.tx == TX_TRAIN && st.tseq[0]) |=>
        st.lane_byte[LANES-1] == {1'b0, D5_6_BYTE})
        else $error("odd training word is not the transition symbol");
    a_train_finish:
    assert property ((st.tx == TX_TRAIN && st.tseq != 3'h7) |=> st.tx == TX_TRAIN)
        else $error("training left before the sequence ended");
    a_train_end:
    assert property ((st.tx == TX_TRAIN && st.tseq == 3'h7 && !req) |=> st.tx == TX_DATA)
        else $error("training kept after release");
    a_train_enter:
    assert property ((st.tx == TX_DATA && req && !st.tab_b[BIT_NO_TRAIN] &&
        st.div4 == WORD_LAST && !swallow) |=> (st.tx == TX_TRAIN && st.tseq == 3'h0 &&
        st.div4 == 2'h0))
        else $error("training did not start at the frame boundary");
    a_train_block:
    assert property ((st.tx == TX_DATA && st.tab_b[BIT_NO_TRAIN]) |=> st.tx == TX_DATA)
        else $error("training started while suppressed");
    a_phase_load:
    assert property ((req && !st.req_q) |=> st.sync_reg[SYNC_PHASE_LSB +: 2] == $past(st.div4))
        else $error("captured phase differs from divider");
    a_clock_swallow:
    assert property (swallow |=> ##1 st.div4 == 2'($past(st.div4, 2) + 2'h1))
        else $error("bump did not drop exactly one clock");
    a_div4_step:
    assert property (!swallow |=> st.div4 == 2'($past(st.div4) + 2'h1))
        else $error("divider did not advance");
    a_map_lane:
    assert property ((st.tx == TX_DATA && st.div4 == 2'h0) |=>
        st.lane_byte[8] == {1'b0, $past(st.frame[1].dly[0])})
        else $error("lane nine word one is not the second delayed A");
    a_table_off:
    assert property ((ser_mode == SER_TABLE0 && !st.ser_lane[1]) |=> lanes_out[1] == '0)
        else $error("deselected table lane not zero");
    a_out_enc:
    assert property ((ser_mode == SER_OFF) |=> lanes_out[1] == $past(enc_sym[1]))
        else $error("lane does not carry encoder output");

    c_training: cover property (st.tx == TX_TRAIN && st.tseq == 3'h7 ##1 st.tx == TX_DATA);
    c_capture: cover property (req && !st.req_q);
    c_swallow: cover property (swallow);
    c_lfsr: cover property (ser_mode == SER_LFSR_STEP5 [*8]);
endmodule

/* File: verif/alf_deser_model.sv */
`timescale 1ns/10ps
module alf_deser_model (
    input wire logic clk,
    input wire logic reset_n,
    input alf_pkg::alf_lanes_t lanes,
    output logic [7:0] starts,
    output logic split
);
    import alf_pkg::*;
    logic all_eq;
    // a start symbol only counts when every lane carries it in the same period
    always_comb begin
        all_eq = 1'b1;
        for (int l = 1; l < LANES; l++) begin
            if (lanes[l] !== lanes[0]) all_eq = 1'b0;
        end
    end
    // counts training starts; a split flag sticks so one skewed lane is never missed
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            starts <= 8'h00;
            split <= 1'b0;
        end else if (lanes[0] == K27_7_NEG || lanes[0] == K27_7_POS) begin
            if (all_eq) starts <= starts + 8'h01;
            else split <= 1'b1;
        end
    end
endmodule

/* File: verif/alf_lane_framer_tb.sv */
`timescale 1ns/10ps
module alf_lane_framer_tb;
    import alf_pkg::*;
    // neutral-disparity bytes and codes, so expected symbols never depend on history
    localparam logic [7:0] BYT [9] = '{8'h45, 8'hA5, 8'hC5, 8'h4A, 8'hAA, 8'hCA, 8'h55,
        8'hB5, 8'hD5};
    localparam logic [9:0] COD [9] = '{10'h295, 10'h29A, 10'h296, 10'h155, 10'h15A,
        10'h156, 10'h2A5, 10'h2AA, 10'h2A6};
    localparam logic [9:0] SLOT [4] = '{10'h155, 10'h2AA, 10'h0F0, 10'h30C};
    localparam logic [9:0] SEL = 10'h259;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sync_request = 1'b0;
    alf_frame_t frame_in;
    alf_reg_req_t reg_req = '0;
    logic [15:0] reg_rdata;
    logic frame_take;
    alf_lanes_t lanes_out;
    logic [7:0] starts;
    logic split;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    alf_lane_framer #(.SYNC_TAPS(4)) alf_lane_framer_i (.clk(clk), .reset_n(reset_n),
        .sync_request(sync_request), .frame_in(frame_in), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .frame_take(frame_take), .lanes_out(lanes_out));
    alf_deser_model alf_deser_model_i (.clk(clk), .reset_n(reset_n), .lanes(lanes_out),
        .starts(starts), .split(split));

    // clock, plus a cycle count that places request edges on a known divider phase
    initial forever #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [9:0] exp_sym(int w, int l);
        int k;
        k = 10 * w + l;
        return COD[(k % 8 + 2 * (k / 8)) % 9];
    endfunction
    function automatic logic [9:0] tab_exp(logic [2:0] m, logic s, int c);
        if (m == SER_TABLE0) return s ? SLOT[c % 4] : 10'h000;
        return SLOT[{s, c[0]}];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // register port: strobe for one cycle, read data lags the address by one edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_req = '{1'b1, a, d};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_req = '{1'b0, a, 16'h0000};
        @(negedge clk);
        d = reg_rdata;
    endtask
    // finds word 0 after a frame capture, then checks four whole words
    task automatic check_frame();
        int n;
        n = 0;
        while (frame_take !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        while (lanes_out[0] !== exp_sym(0, 0) && n < 24) begin
            @(negedge clk);
            n++;
        end
        for (int w = 0; w < 4; w++) begin
            for (int l = 0; l < LANES; l++) chk(lanes_out[l], exp_sym(w, l));
            @(negedge clk);
        end
    endtask
    task automatic test_regs();
        logic [15:0] d;
        logic [4:0] a [7];
        a = '{ADDR_CORE_CFG, ADDR_PATTERN, ADDR_SYNC, ADDR_SER_LANE, ADDR_TAB_A, ADDR_TAB_B,
            ADDR_SER_PAT};
        foreach (a[i]) begin
            rd(a[i], d);
            chk(d, RST_REG);
        end
        wr(ADDR_SYNC, 16'hFFE0);
        rd(ADDR_SYNC, d);
        chk(d, 16'hFF80);
        wr(ADDR_SYNC, 16'h0000);
        wr(ADDR_TAB_A, 16'hA5C3);
        rd(ADDR_TAB_A, d);
        chk(d, 16'hA5C3);
        wr(5'h1F, 16'h1234);
        rd(5'h1F, d);
        chk(d, 16'h0000);
        $display("test_regs done");
    endtask
    // core mode and the unused serializer code 7 must leave the mapping alone
    task automatic test_map();
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CORE_CFG, {2'(m), 14'h0000});
            check_frame();
        end
        wr(ADDR_CORE_CFG, 16'h0000);
        wr(ADDR_SER_PAT, 16'h1C00);
        check_frame();
        wr(ADDR_SER_PAT, 16'h0000);
        $display("test_map done");
    endtask
    // release lands mid-sequence: the sequence must finish before data word 0
    task automatic test_train();
        logic [9:0] seq [16];
        logic [7:0] s0;
        int n;
        // three commas per sequence flip disparity, so the second pass uses the other codes
        seq = '{10'h368, 10'h296, 10'h0FA, 10'h296, 10'h305, 10'h296, 10'h0FA, 10'h296,
            10'h097, 10'h296, 10'h305, 10'h296, 10'h0FA, 10'h296, 10'h305, 10'h296};
        s0 = starts;
        @(negedge clk);
        sync_request = 1'b1;
        n = 0;
        while (lanes_out[0] !== seq[0] && n < 40) begin
            @(negedge clk);
            n++;
        end
        for (int r = 0; r < 18; r++) begin
            if (r == 5) sync_request = 1'b0;
            for (int l = 0; l < LANES; l++) begin
                if (r < 16) chk(lanes_out[l], seq[r]);
                else chk(lanes_out[l], exp_sym(r - 16, l));
            end
            @(negedge clk);
        end
        chk(starts, 8'(s0 + 8'h02));
        chk(split, 1'b0);
        $display("test_train done");
    endtask
    // request rises on a chosen divider phase, data is checked while it is held
    task automatic capture(input int m, output logic [1:0] ph);
        logic [15:0] d;
        do @(negedge clk); while (cyc % 4 != m);
        sync_request = 1'b1;
        check_frame();
        sync_request = 1'b0;
        repeat (8) @(negedge clk);
        rd(ADDR_SYNC, d);
        ph = d[6:5];
    endtask
    task automatic test_capture();
        logic [1:0] p0;
        logic [1:0] p;
        logic [7:0] s0;
        wr(ADDR_TAB_B, 16'h4000);
        s0 = starts;
        capture(0, p0);
        for (int m = 1; m < 4; m++) begin
            capture(m, p);
            chk(p, 2'(p0 + m));
        end
        wr(ADDR_SYNC, 16'h0080);
        capture(0, p);
        chk(p, 2'(p0 + 2'h1));
        wr(ADDR_SYNC, 16'h0000);
        wr(ADDR_CORE_CFG, 16'h0002);
        wr(ADDR_CORE_CFG, 16'h0000);
        capture(0, p);
        chk(p, 2'(p0 - 2'h1));
        chk(starts, s0);
        wr(ADDR_TAB_B, 16'h0000);
        $display("test_capture done");
    endtask
    // all-low and all-high converter patterns, whatever the sample input holds
    task automatic test_pattern();
        logic [15:0] pat [2];
        logic [9:0] sym [2];
        pat = '{16'h0000, 16'hFFFF};
        sym = '{10'h274, 10'h2B1};
        wr(ADDR_CORE_CFG, 16'h0008);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_PATTERN, pat[i]);
            repeat (12) @(negedge clk);
            for (int l = 0; l < LANES; l++) chk(lanes_out[l], sym[i]);
        end
        wr(ADDR_CORE_CFG, 16'h0000);
        $display("test_pattern done");
    endtask
    task automatic test_table(input logic [2:0] mode);
        int c;
        wr(ADDR_SER_LANE, {6'h00, SEL});
        wr(ADDR_TAB_A, {SLOT[1][5:0], SLOT[0]});
        wr(ADDR_TAB_B, {2'b00, SLOT[2], SLOT[1][9:6]});
        wr(ADDR_SER_PAT, {3'b000, mode, SLOT[3]});
        @(negedge clk);
        c = 0;
        while (tab_exp(mode, 1'b1, c) !== lanes_out[0] && c < 3) c++;
        for (int t = 0; t < 6; t++) begin
            for (int l = 0; l < LANES; l++) chk(lanes_out[l], tab_exp(mode, SEL[l], c + t));
            @(negedge clk);
        end
        $display("test_table done");
    endtask
    // lane 0 marks the period start; later lanes start step symbols apart
    task automatic test_lfsr(input logic [2:0] mode, input int step);
        logic [9:0] prev;
        int n;
        wr(ADDR_SER_PAT, {3'b000, mode, 10'h000});
        prev = 10'h000;
        n = 0;
        while (!(prev === K28_5_NEG && lanes_out[0] === K28_5_POS) && n < 140) begin
            prev = lanes_out[0];
            @(negedge clk);
            n++;
        end
        for (int t = 1; t < 70; t++) begin
            for (int l = 0; l < LANES; l++) begin
                if ((t - l * step + 128) % 64 == 0) chk(lanes_out[l], K28_5_NEG);
                if ((t - l * step + 128) % 64 == 1) chk(lanes_out[l], K28_5_POS);
            end
            @(negedge clk);
        end
        $display("test_lfsr done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // cuts a hang short, far beyond the several hundred cycles the tests need
    initial begin
        #2000000;
        num_errors++;
        final_report();
    end
    initial begin
        for (int s = 0; s < SETS; s++) begin
            for (int c = 0; c < CORES; c++) begin
                frame_in[s].dly[c] = BYT[(c + 2 * s) % 9];
                frame_in[s].cur[c] = BYT[(c + 4 + 2 * s) % 9];
            end
        end
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        test_regs();
        test_map();
        test_train();
        test_capture();
        test_pattern();
        test_table(SER_TABLE0);
        test_table(SER_TABLE1);
        test_lfsr(SER_LFSR_ALIGNED, 0);
        test_lfsr(SER_LFSR_STEP1, 1);
        test_lfsr(SER_LFSR_STEP5, LFSR_WIDE_STEP);
        wr(ADDR_SER_PAT, 16'h0000);
        check_frame();
        final_report();
    end
endmodule
